// ===== hdl/tps_defs.svh
// Constants for the primary timer, the shared scaler and the pin sync
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

// Option field layout, low four bits of the option configuration
`define TPS_OPT_W              4
`define TPS_OPT_ASSIGN_BIT     3
`define TPS_OPT_RATIO_MSB      2
`define TPS_OPT_RATIO_LSB      0
`define TPS_OPT_RATIO_W        3
`define TPS_OPT_RESET          4'hf

// Reset value of one bit of the scaler and of the timer count
`define TPS_SCALER_RESET_BIT   1'h0
`define TPS_TMR_RESET_BIT      1'h0

// Clock: mclk period and oscillator period, both in picoseconds
`define TPS_MCLK_PERIOD_PS     8000
`define TPS_TOSC_PS            8000
`define TPS_TOSC_CYC ((`TPS_TOSC_PS + `TPS_MCLK_PERIOD_PS - 1) / `TPS_MCLK_PERIOD_PS)

// Pin timing the source must keep, in oscillator periods
`define TPS_PIN_HIGH_MIN_TOSC  2
`define TPS_PIN_LOW_MIN_TOSC   2
`define TPS_PIN_PERIOD_MIN_TOSC 4

// Pin change to timer increment, in oscillator periods
`define TPS_INC_DELAY_MIN_TOSC 3
`define TPS_INC_DELAY_MAX_TOSC 7

// Synchroniser depth on the pin
`define TPS_SYNC_STAGES        2

`endif

// ===== hdl/tps_pkg.sv
// Types shared by the primary timer files
package tps_pkg;
   // Four internal phases, Gray coded along the cycle
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } tps_phase_t;

   // Owner of the shared scaler
   typedef enum logic {
      ASSIGN_TIMER = 1'b0,
      ASSIGN_WDOG  = 1'b1
   } tps_assign_t;
endpackage

// ===== hdl/tps_scaler.sv
// Shared scaler counter with clear and a selectable output tap
`timescale 1ns/1ps
`include "tps_defs.svh"
module tps_scaler #(
   parameter int SCALER_W = 8
) (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic                        count_en,
   input  wire logic                        clr,
   input  wire logic [`TPS_OPT_RATIO_W-1:0] tap_sel,
   output      logic [SCALER_W-1:0]         cnt_reg,
   output      logic                        tap
);
   // Refuse a counter too short for the largest tap
   if (SCALER_W < 8) begin : g_bad_width
      $error("tps_scaler: SCALER_W must be at least 8");
   end

   // Count up on each enable; a clear wins over a count
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= {SCALER_W{`TPS_SCALER_RESET_BIT}};
      end else if (clr) begin
         cnt_reg <= {SCALER_W{`TPS_SCALER_RESET_BIT}};
      end else if (count_en) begin
         cnt_reg <= cnt_reg + {{(SCALER_W-1){1'h0}}, 1'h1};
      end
   end

   // Each bit is a square wave, so the tap is symmetrical
   assign tap = cnt_reg[tap_sel];
endmodule

// ===== hdl/tps_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`include "tps_defs.svh"
module tps_sync2 (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output      logic sync_out
);
   logic meta_reg;   // First stage, read only by the second

   // Two stages; nothing but sync_out looks at the first
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 1'h0;
         sync_out <= 1'h0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ===== hdl/tps_timer.sv
// Primary timer with shared scaler, pin clock sync and watchdog postscale
`timescale 1ns/1ps
`include "tps_defs.svh"
// How it works
// - Without scaler, selected source level is the scaler output
// - Scaler output sampled in phase two, four
// - Scaler divides pin into symmetrical output
// - Increment three to seven periods after edge
// - One scaler shared, timer or watchdog only
// - Assign bit and ratio from option bits
// - Timer write clears scaler while timer-assigned
// - Watchdog clear clears scaler while watchdog-assigned
// - Scaler count has no software access path
// - Reset loads scaler with all zeros
// - Option write may move scaler any time
module tps_timer #(
   parameter int SCALER_W = 8,
   parameter int TMR_W    = 8
) (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic                   timer_ext_clock_in,
   input  wire logic                   count_src_sel,
   input  wire logic                   opt_wr,
   input  wire logic [`TPS_OPT_W-1:0]  opt_wdata,
   input  wire logic                   tmr_wr,
   input  wire logic [TMR_W-1:0]       tmr_wdata,
   input  wire logic                   clear_watchdog_op,
   input  wire logic                   wdt_tick,
   output      logic [TMR_W-1:0]       timer_count_reg,
   output      logic                   wdt_scaled_tick,
   output      logic                   wdt_clear_out,
   output      tps_pkg::tps_phase_t    phase_out
);
   import tps_pkg::*;

   // Latency from a synchronised rise to the increment pulse
   localparam int INC_LAT_MIN = 1;
   localparam int INC_LAT_MAX = 2;
   // Worst pin-to-count path: sync stages, phase wait, count update
   localparam int PATH_MAX = `TPS_SYNC_STAGES + INC_LAT_MAX + 1;

   // Refuse widths and a pin path the logic cannot serve
   if (TMR_W < 1) begin : g_bad_tmr
      $error("tps_timer: TMR_W must be at least 1");
   end
   if (PATH_MAX > `TPS_INC_DELAY_MAX_TOSC * `TPS_TOSC_CYC) begin : g_bad_path
      $error("tps_timer: increment path longer than allowed");
   end

   // Next phase along the four-phase cycle
   function automatic tps_phase_t next_phase(input tps_phase_t p);
      unique case (p)
         PH_Q1:   next_phase = PH_Q2;
         PH_Q2:   next_phase = PH_Q3;
         PH_Q3:   next_phase = PH_Q4;
         PH_Q4:   next_phase = PH_Q1;
      endcase
   endfunction

   // True in the phases where the scaler output is sampled
   function automatic logic is_sample_phase(input tps_phase_t p);
      is_sample_phase = (p == PH_Q2) || (p == PH_Q4);
   endfunction

   tps_phase_t                  phase_reg;       // Current internal phase
   tps_phase_t                  phase_next;      // Following phase
   logic [`TPS_OPT_W-1:0]       opt_reg;         // Option configuration bits
   logic                        assign_timer;    // Scaler belongs to timer
   logic [`TPS_OPT_RATIO_W-1:0] ratio;           // Division ratio field
   logic                        ext_sync;        // Pin after two flops
   logic                        inst_level;      // Instruction clock level
   logic                        src_level;       // Selected count source
   logic                        src_d_reg;       // Source one cycle back
   logic                        src_rise;        // Rising source edge
   logic                        scaler_en;       // Scaler count enable
   logic                        scaler_clr;      // Scaler clear
   logic [`TPS_OPT_RATIO_W-1:0] tap_sel;         // Scaler tap index
   logic [SCALER_W-1:0]         scaler_cnt;      // Scaler value, internal
   logic                        scaler_tap;      // Selected scaler bit
   logic                        presc_out;       // Output fed to sampling
   logic                        sample_reg;      // Sampled scaler output
   logic                        sample_d_reg;    // Sample one cycle back
   logic                        inc_pulse;       // One-cycle increment
   logic                        wdt_tap_d_reg;   // Tap one cycle back
   logic                        wdt_scaled_next; // Next watchdog tick
   logic [TMR_W-1:0]            timer_next;      // Next timer count

   // Pin crosses into the mclk domain before anything reads it
   tps_sync2 u_sync (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (timer_ext_clock_in),
      .sync_out (ext_sync)
   );

   // Four-phase instruction cycle, one phase per oscillator period
   assign phase_next = next_phase(phase_reg);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= PH_Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end
   assign phase_out = phase_reg;

   // Option bits, rewritable at any time by the core
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         opt_reg <= `TPS_OPT_RESET;
      end else if (opt_wr) begin
         opt_reg <= opt_wdata;
      end
   end

   // Decode assignment and ratio from the low option bits
   assign assign_timer = (opt_reg[`TPS_OPT_ASSIGN_BIT] == ASSIGN_TIMER);
   assign ratio        = opt_reg[`TPS_OPT_RATIO_MSB:`TPS_OPT_RATIO_LSB];

   // Internal source is high in the second half of each cycle
   assign inst_level = (phase_reg == PH_Q3) || (phase_reg == PH_Q4);
   assign src_level  = count_src_sel ? ext_sync : inst_level;

   // Source edge history for the scaler
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         src_d_reg <= 1'h0;
      end else begin
         src_d_reg <= src_level;
      end
   end
   assign src_rise = src_level & ~src_d_reg;

   // One counter: timer edges or watchdog ticks, never both
   assign scaler_en  = assign_timer ? src_rise : wdt_tick;
   // Timer write or watchdog clear, by owner
   assign scaler_clr = assign_timer ? tmr_wr : clear_watchdog_op;
   // Timer ratio 1:2^(n+1), watchdog ratio 1:2^n
   assign tap_sel    = assign_timer ? ratio : ratio - 3'h1;

   // Shared scaler; its count never reaches a port
   tps_scaler #(
      .SCALER_W (SCALER_W)
   ) u_scaler (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .count_en (scaler_en),
      .clr      (scaler_clr),
      .tap_sel  (tap_sel),
      .cnt_reg  (scaler_cnt),
      .tap      (scaler_tap)
   );

   // Bypass: the selected source level itself when the watchdog owns the scaler
   assign presc_out = assign_timer ? scaler_tap : src_level;

   // Sample only in phases two and four, relying on wide enough pulses
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sample_reg <= 1'h0;
      end else if (is_sample_phase(phase_reg)) begin
         sample_reg <= presc_out;
      end
   end

   // Edge detect on the sampled output
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sample_d_reg <= 1'h0;
      end else begin
         sample_d_reg <= sample_reg;
      end
   end
   assign inc_pulse = sample_reg & ~sample_d_reg;

   // Timer count: a core write wins, else count up and wrap
   always_comb begin
      if (tmr_wr) begin
         timer_next = tmr_wdata;
      end else if (inc_pulse) begin
         timer_next = timer_count_reg + {{(TMR_W-1){1'h0}}, 1'h1};
      end else begin
         timer_next = timer_count_reg;
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_count_reg <= {TMR_W{`TPS_TMR_RESET_BIT}};
      end else begin
         timer_count_reg <= timer_next;
      end
   end

   // Tap history for the watchdog postscale edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_tap_d_reg <= 1'h0;
      end else begin
         wdt_tap_d_reg <= scaler_tap;
      end
   end

   // Watchdog tick: raw when unscaled or ratio zero, else tap edge
   always_comb begin
      if (assign_timer || (ratio == 3'h0)) begin
         wdt_scaled_next = wdt_tick;
      end else begin
         wdt_scaled_next = scaler_tap & ~wdt_tap_d_reg;
      end
   end

   // Registered watchdog outputs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_scaled_tick <= 1'h0;
         wdt_clear_out   <= 1'h0;
      end else begin
         wdt_scaled_tick <= wdt_scaled_next;
         wdt_clear_out   <= clear_watchdog_op;
      end
   end

   // Phases run Q1 to Q4 and back in order
   a_phase_order: assert property (@(posedge mclk) disable iff (sys_rst)
      (phase_reg == PH_Q1) |=> (phase_reg == PH_Q2) ##1 (phase_reg == PH_Q3)
         ##1 (phase_reg == PH_Q4) ##1 (phase_reg == PH_Q1))
      else $error("phase sequence broken");

   // Sample holds outside the sampling phases
   a_sample_phase: assert property (@(posedge mclk) disable iff (sys_rst)
      ((phase_reg == PH_Q1) || (phase_reg == PH_Q3)) |=> $stable(sample_reg))
      else $error("sample changed outside phase two or four");

   // Sample taken in phase two or four follows the scaler output
   a_sample_value: assert property (@(posedge mclk) disable iff (sys_rst)
      is_sample_phase(phase_reg) |=> (sample_reg == $past(presc_out)))
      else $error("sample does not follow scaler output");

   // Bypass passes the pin level, two sync stages late, straight through
   a_bypass_path: assert property (@(posedge mclk) disable iff (sys_rst)
      (!assign_timer && count_src_sel && !$past(sys_rst, 2))
         |-> (presc_out == $past(timer_ext_clock_in, 2)))
      else $error("bypass does not pass pin level");

   // Synchronised pin rise gives an increment within two cycles
   a_inc_latency: assert property (@(posedge mclk) disable iff (sys_rst)
      ($rose(ext_sync) && count_src_sel && !assign_timer && !sample_reg)
         |-> ##[INC_LAT_MIN:INC_LAT_MAX] inc_pulse)
      else $error("increment late after pin edge");

   // Increment adds exactly one and wraps
   a_timer_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
      (inc_pulse && !tmr_wr)
         |=> (timer_count_reg == TMR_W'($past(timer_count_reg) + 1)))
      else $error("timer did not add one");

   // Timer write clears the timer-owned scaler
   a_wr_clr_scaler: assert property (@(posedge mclk) disable iff (sys_rst)
      (tmr_wr && assign_timer)
         |=> ((scaler_cnt == '0) && (timer_count_reg == $past(tmr_wdata))))
      else $error("timer write did not clear scaler");

   // Watchdog clear clears the watchdog-owned scaler and the watchdog
   a_wdog_clr_scaler: assert property (@(posedge mclk) disable iff (sys_rst)
      (clear_watchdog_op && !assign_timer) |=> ((scaler_cnt == '0) && wdt_clear_out))
      else $error("watchdog clear did not clear scaler");

   // Scaler leaves reset at zero
   a_reset_zero: assert property (@(posedge mclk)
      $fell(sys_rst) |-> (scaler_cnt == '0))
      else $error("scaler not zero after reset");

   // Option write lands in the option bits
   a_opt_write: assert property (@(posedge mclk) disable iff (sys_rst)
      opt_wr |=> (opt_reg == $past(opt_wdata)))
      else $error("option write lost");

   // Timer-owned scaler leaves watchdog ticks unscaled
   a_wdog_unscaled: assert property (@(posedge mclk) disable iff (sys_rst)
      assign_timer |=> (wdt_scaled_tick == $past(wdt_tick)))
      else $error("watchdog scaled while scaler is timer-owned");

   // Timer-owned scaler follows timer source edges and timer writes only
   a_scaler_owner: assert property (@(posedge mclk) disable iff (sys_rst)
      (assign_timer && !src_rise && !tmr_wr) |=> $stable(scaler_cnt))
      else $error("timer-owned scaler counted without edge");

   // Watchdog-owned scaler ignores the timer source
   a_wdog_owner: assert property (@(posedge mclk) disable iff (sys_rst)
      (!assign_timer && !wdt_tick && !clear_watchdog_op) |=> $stable(scaler_cnt))
      else $error("watchdog-owned scaler counted without tick");

   // Timer count holds without a write or an increment
   a_timer_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      (!inc_pulse && !tmr_wr) |=> $stable(timer_count_reg))
      else $error("timer changed without write or increment");

   // Increment pulse lasts a single cycle
   a_inc_single: assert property (@(posedge mclk) disable iff (sys_rst)
      inc_pulse |=> !inc_pulse)
      else $error("increment pulse longer than one cycle");
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the primary timer and its shared scaler
`timescale 1ns/1ps
module tb_top;
   import tps_pkg::*;
   logic        mclk;            // Core clock
   logic        sys_rst;         // Reset, active high
   logic        pin;             // Count pin from the source model
   logic        cs;              // Count source select
   logic        opt_wr;          // Option write strobe
   logic [3:0]  opt_d;           // Option data
   logic        tmr_wr;          // Timer write strobe
   logic [7:0]  tmr_d;           // Timer write data
   logic        clr_op;          // Clear-watchdog strobe
   logic        tick;            // Raw watchdog tick
   logic [7:0]  cnt;             // Timer count seen
   logic        stick;           // Scaled watchdog tick
   logic        wclr;            // Clear sent to the watchdog
   tps_phase_t  ph;              // Internal phase
   int          fails;           // Mismatches
   int          samples_checked; // Comparisons
   int          wcnt = 0;        // Scaled ticks seen
   logic [31:0] seed;            // Random state

   tps_timer u_tps_timer (.mclk(mclk), .sys_rst(sys_rst), .timer_ext_clock_in(pin),
      .count_src_sel(cs), .opt_wr(opt_wr), .opt_wdata(opt_d), .tmr_wr(tmr_wr),
      .tmr_wdata(tmr_d), .clear_watchdog_op(clr_op), .wdt_tick(tick),
      .timer_count_reg(cnt), .wdt_scaled_tick(stick), .wdt_clear_out(wclr),
      .phase_out(ph));
   tps_src_model u_tps_src_model (.mclk(mclk), .timer_ext_clock_in(pin));

   // Free-running clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Count scaled watchdog ticks
   always @(posedge mclk) begin
      if (stick === 1'b1) begin
         wcnt++;
      end
   end

   // Xorshift source of repeatable values
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Random pin level width, two to five cycles
   function automatic int rnd_w();
      return 2 + int'(rnd() % 4);
   endfunction

   // Scaled ticks expected after t raw ticks from a cleared scaler
   function automatic int exp_wdt(input int n, input int t);
      int h;
      h = (n == 0) ? 1 : (1 << (n - 1));
      if (n == 0) begin
         return t;
      end
      return (t >= h) ? 1 + (t - h) / (2 * h) : 0;
   endfunction

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   // Print counts and verdict, then end the run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Option write, one cycle strobe
   task automatic opt(input logic [3:0] v);
      @(posedge mclk);
      opt_wr <= 1'b1;
      opt_d  <= v;
      @(posedge mclk);
      opt_wr <= 1'b0;
   endtask

   // Timer write; count follows one cycle later
   task automatic wr_tmr(input logic [7:0] v);
      @(posedge mclk);
      tmr_wr <= 1'b1;
      tmr_d  <= v;
      @(posedge mclk);
      tmr_wr <= 1'b0;
      #1 chk("timer write", v, cnt);
   endtask

   // Clear-watchdog operation; clear pulse stands one cycle
   task automatic clr_wdt();
      @(posedge mclk);
      clr_op <= 1'b1;
      @(posedge mclk);
      clr_op <= 1'b0;
      #1 chk("wdt clear", 1, wclr);
      @(posedge mclk);
      #1 chk("wdt clear end", 0, wclr);
   endtask

   // Raw watchdog ticks, then let the last scaled tick land
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk);
         tick <= 1'b1;
         @(posedge mclk);
         tick <= 1'b0;
      end
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // Pin periods of random widths, then wait out the sync delay
   task automatic pins(input int n);
      repeat (n) u_tps_src_model.pulse(rnd_w(), rnd_w());
      repeat (10) @(posedge mclk);
      #1;
   endtask

   // One unscaled pin period, timing the count change from the rise
   task automatic lat_pulse();
      logic [7:0] old;
      int         n;
      old = cnt;
      n = 0;
      fork
         u_tps_src_model.pulse(rnd_w(), rnd_w());
         begin
            @(posedge mclk);
            while (cnt === old && n < 10) begin
               @(posedge mclk);
               #1;
               n++;
            end
         end
      join
      chk("increment delay", 1, n >= 3 && n <= 7);
      if (n >= 10) begin
         report_and_stop();
      end
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      int         p;
      int         d8;
      int         w0;
      logic [7:0] d;
      logic [7:0] old;
      tps_phase_t seq [4];
      seq = '{PH_Q2, PH_Q3, PH_Q4, PH_Q1};
      seed = 32'h9288;
      sys_rst = 1'b1;
      cs = 1'b1;
      opt_wr = 1'b0;
      opt_d = 4'h0;
      tmr_wr = 1'b0;
      tmr_d = 8'h00;
      clr_op = 1'b0;
      tick = 1'b0;
      fails = 0;
      samples_checked = 0;
      repeat (5) @(posedge mclk);
      #1 chk("reset count", 0, cnt);
      chk("reset phase", PH_Q1, ph);
      chk("reset scaled tick", 0, stick);
      @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         #1 chk("phase", seq[i % 4], ph);
      end
      // Watchdog owns the scaler after reset: pin counts unscaled, with wrap
      wr_tmr(8'hfd);
      repeat (6) lat_pulse();
      chk("bypass count", 8'h03, cnt);
      // Internal source, one count per four cycles
      @(posedge mclk);
      cs <= 1'b0;
      #1 old = cnt;
      repeat (40) @(posedge mclk);
      #1 d8 = int'(8'(cnt - old));
      chk("internal count", 1, d8 >= 9 && d8 <= 11);
      @(posedge mclk);
      cs <= 1'b1;
      // Scaler on the timer, every ratio
      for (int r = 0; r < 8; r++) begin
         clr_wdt();
         d = 8'(rnd());
         wr_tmr(d);
         opt({1'b0, 3'(r)});
         pins((1 << r) - 1);
         wr_tmr(d);
         pins((1 << r) - 1);
         chk("scaler cleared", d, cnt);
         pins(1);
         chk("first tap", 8'(d + 1), cnt);
         pins(2 << r);
         chk("prescale", 8'(d + 2), cnt);
      end
      // Reset in mid-run empties a half-filled scaler
      clr_wdt();
      opt(4'b0001);
      wr_tmr(8'h5a);
      pins(1);
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk("reset count", 0, cnt);
      opt(4'b0001);
      pins(1);
      chk("scaler after reset", 0, cnt);
      pins(1);
      chk("tap after reset", 1, cnt);
      // Timer owns the scaler: watchdog ticks pass one to one
      w0 = wcnt;
      ticks(5);
      chk("unscaled wdt", 5, wcnt - w0);
      // Scaler on the watchdog, every ratio, cleared in mid-count for ratios two to seven
      for (int n = 0; n < 8; n++) begin
         clr_wdt();
         wr_tmr(8'h00);
         opt(4'hf);
         clr_wdt();
         opt({1'b1, 3'(n)});
         p = (n == 0) ? 0 : (1 << (n - 1)) - 1;
         w0 = wcnt;
         ticks(p);
         clr_wdt();
         ticks(p + (1 << n));
         chk("postscale", exp_wdt(n, p + (1 << n)), wcnt - w0);
      end
      report_and_stop();
   end
endmodule

// ===== verif/tps_src_model.sv
// External clock source model that drives the timer count pin
`timescale 1ns/1ps
module tps_src_model (
   input  wire logic mclk,
   output      logic timer_ext_clock_in
);
   // Pin rests low outside frames
   initial timer_ext_clock_in = 1'b0;

   // One pin period; each level lasts at least two cycles, so the
   // period is at least four cycles whatever the prescale value
   task automatic pulse(input int hi, input int lo);
      @(posedge mclk);
      timer_ext_clock_in <= 1'b1;
      repeat ((hi < 2) ? 2 : hi) @(posedge mclk);
      timer_ext_clock_in <= 1'b0;
      repeat (((lo < 2) ? 2 : lo) - 1) @(posedge mclk);
   endtask
endmodule
